// file: rtl/stl_regs.vh
// Purpose: Register map and constants of the servo torque limiter
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: Limits are percent of rated torque
`ifndef STL_REGS_VH
`define STL_REGS_VH
`define STL_ADDR_W 6
`define STL_OFS_FWD_INT 6'h00
`define STL_OFS_REV_INT 6'h04
`define STL_OFS_ROUTING 6'h08
`define STL_OFS_FWD_EXT 6'h0c
`define STL_OFS_REV_EXT 6'h10
`define STL_OFS_MAXTQ 6'h14
`define STL_OFS_IN_MON 6'h18
`define STL_OFS_OUT_MON 6'h1c
`define STL_OFS_IRQ_STAT 6'h20
`define STL_OFS_IRQ_MASK 6'h24
`define STL_RST_INT_LIM 16'h0320
`define STL_RST_EXT_LIM 16'h0064
`define STL_RST_ROUTING 16'h0000
`define STL_RST_MAXTQ 16'h0320
`define STL_LIM_MAX 16'h0320
`define STL_SEL_LSB 0
`define STL_SEL_MSB 1
`define STL_SEL_NONE 2'h0
`define STL_SEL_FIRST 2'h1
`define STL_SEL_SECOND 2'h2
`define STL_SEL_THIRD 2'h3
`define STL_MON_FWD_EXT 6
`define STL_MON_REV_EXT 7
`define STL_OMON_LIMITED 0
`define STL_IRQ_W 3
`define STL_IRQ_LIM_SET 0
`define STL_IRQ_LIM_CLR 1
`define STL_IRQ_EXT_CHG 2
`endif

// file: rtl/stl_torque_limiter.v
// Purpose: Torque limit selection, limited status, routing and monitors
// Assumes: Inputs synchronous to clk_in; torque reference signed percent
// Notes: Registers reached over Avalon-MM, one wait cycle per access
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`include "stl_regs.vh"

// Behaviour
// R1 - Separate forward and reverse internal limits, 0 to 800, default 800, always applied
// R2 - All limit settings are percent of rated torque
// R3 - Limit above motor maximum torque is replaced by the maximum
// R4 - Limited output low while torque reference exceeds active limit, high otherwise
// R5 - Compare torque continuously against internal and external limits
// R6 - Select field routes status nowhere or to output pair one, two, three
// R7 - Several functions on one output pair are ORed together
// R8 - Forward external input low applies forward external limit
// R9 - Reverse external input low applies reverse external limit
// R10 - External limits accept 0 to 800, default 100
// R11 - External limits set and applied per direction independently
// R12 - Input monitor shows external limit inputs at positions 6 and 7
// R13 - Output monitor reflects limited condition
// R14 - Active external limit: effective limit is smaller of internal and external
module stl_torque_limiter (
    input wire clk_in,
    input wire reset_n_in,
    input wire [`STL_ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    input wire signed [15:0] torque_ref_in,
    input wire forward_ext_limit_n_in,
    input wire reverse_ext_limit_n_in,
    input wire [2:0] other_out_func_in,
    output reg [15:0] active_limit_out,
    output reg torque_limited_n_out,
    output reg output_pair_first_n_out,
    output reg output_pair_second_n_out,
    output reg output_pair_third_n_out,
    output wire irq_out
);
    reg [15:0] forward_internal_torque_limit;
    reg [15:0] reverse_internal_torque_limit;
    reg [15:0] output_signal_routing_two;
    reg [15:0] forward_external_torque_limit;
    reg [15:0] reverse_external_torque_limit;
    reg [15:0] motor_max_torque;
    reg [`STL_IRQ_W-1:0] irq_status;
    reg [`STL_IRQ_W-1:0] irq_mask;
    reg ack;
    reg limited;
    reg [1:0] ext_prev;
    reg [15:0] fwd_lim;
    reg [15:0] rev_lim;
    reg [15:0] next_active;
    reg [15:0] mag;
    reg next_limited;
    reg [31:0] rd_mux;
    reg [2:0] pair_hit;
    wire fwd_ext_on;
    wire rev_ext_on;
    wire [1:0] sel;
    wire acc;
    wire wr_en;
    wire rd_en;
    wire rd_cap;
    wire [7:0] in_mon;
    wire [`STL_IRQ_W-1:0] events;

    // Software limit settings saturate at the documented top of range
    function [15:0] clip_set;
        input [15:0] v;
        begin
            clip_set = (v > `STL_LIM_MAX) ? `STL_LIM_MAX : v; // R1 R10
        end
    endfunction

    // Byte-lane merge for 16-bit registers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] be;
        begin
            merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    assign fwd_ext_on = ~forward_ext_limit_n_in; // R8
    assign rev_ext_on = ~reverse_ext_limit_n_in; // R9
    assign sel = output_signal_routing_two[`STL_SEL_MSB:`STL_SEL_LSB];
    assign acc = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = acc & ~ack;
    assign wr_en = avs_write_in & ack;
    assign rd_en = avs_read_in & ack;
    // Read data captured on the taking edge so it stands when waitrequest drops
    assign rd_cap = avs_read_in & ~ack;
    assign in_mon = {rev_ext_on, fwd_ext_on, 6'h00}; // R12
    assign events = {(ext_prev != {rev_ext_on, fwd_ext_on}), limited & ~next_limited,
                     next_limited & ~limited};
    assign irq_out = |(irq_status & irq_mask);

    // Effective limit per direction, percent of rated torque
    always @* begin
        fwd_lim = forward_internal_torque_limit; // R1 R2
        if (fwd_ext_on && forward_external_torque_limit < fwd_lim) begin
            fwd_lim = forward_external_torque_limit; // R8 R11 R14
        end
        if (fwd_lim > motor_max_torque) begin
            fwd_lim = motor_max_torque; // R3
        end
        rev_lim = reverse_internal_torque_limit; // R1 R2
        if (rev_ext_on && reverse_external_torque_limit < rev_lim) begin
            rev_lim = reverse_external_torque_limit; // R9 R11 R14
        end
        if (rev_lim > motor_max_torque) begin
            rev_lim = motor_max_torque; // R3
        end
        if (torque_ref_in[15]) begin
            mag = 16'h0000 - torque_ref_in;
            next_active = rev_lim;
        end else begin
            mag = torque_ref_in;
            next_active = fwd_lim;
        end
        next_limited = (mag > next_active); // R4 R5
    end

    // Pair routing with OR of other functions
    always @* begin
        pair_hit = other_out_func_in;
        case (sel)
            `STL_SEL_FIRST: pair_hit[0] = other_out_func_in[0] | next_limited; // R6 R7
            `STL_SEL_SECOND: pair_hit[1] = other_out_func_in[1] | next_limited; // R6 R7
            `STL_SEL_THIRD: pair_hit[2] = other_out_func_in[2] | next_limited; // R6 R7
            default: pair_hit = other_out_func_in; // R6
        endcase
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address_in)
            `STL_OFS_FWD_INT: rd_mux[15:0] = forward_internal_torque_limit;
            `STL_OFS_REV_INT: rd_mux[15:0] = reverse_internal_torque_limit;
            `STL_OFS_ROUTING: rd_mux[15:0] = output_signal_routing_two;
            `STL_OFS_FWD_EXT: rd_mux[15:0] = forward_external_torque_limit;
            `STL_OFS_REV_EXT: rd_mux[15:0] = reverse_external_torque_limit;
            `STL_OFS_MAXTQ: rd_mux[15:0] = motor_max_torque;
            `STL_OFS_IN_MON: rd_mux[7:0] = in_mon; // R12
            `STL_OFS_OUT_MON: rd_mux[`STL_OMON_LIMITED] = limited; // R13
            `STL_OFS_IRQ_STAT: rd_mux[`STL_IRQ_W-1:0] = irq_status;
            `STL_OFS_IRQ_MASK: rd_mux[`STL_IRQ_W-1:0] = irq_mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            forward_internal_torque_limit <= `STL_RST_INT_LIM;
            reverse_internal_torque_limit <= `STL_RST_INT_LIM;
            output_signal_routing_two <= `STL_RST_ROUTING;
            forward_external_torque_limit <= `STL_RST_EXT_LIM; // R10
            reverse_external_torque_limit <= `STL_RST_EXT_LIM; // R10
            motor_max_torque <= `STL_RST_MAXTQ;
            irq_status <= {`STL_IRQ_W{1'b0}};
            irq_mask <= {`STL_IRQ_W{1'b0}};
            ack <= 1'b0;
            limited <= 1'b0;
            ext_prev <= 2'b00;
            active_limit_out <= `STL_RST_INT_LIM;
            torque_limited_n_out <= 1'b1;
            output_pair_first_n_out <= 1'b1;
            output_pair_second_n_out <= 1'b1;
            output_pair_third_n_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack <= acc & ~ack;
            limited <= next_limited; // R4 R5
            ext_prev <= {rev_ext_on, fwd_ext_on};
            active_limit_out <= next_active;
            torque_limited_n_out <= ~next_limited; // R4
            output_pair_first_n_out <= ~pair_hit[0]; // R7
            output_pair_second_n_out <= ~pair_hit[1]; // R7
            output_pair_third_n_out <= ~pair_hit[2]; // R7
            if (rd_cap) begin
                avs_readdata_out <= rd_mux;
            end
            // Set wins over read-clear
            if (rd_cap && avs_address_in == `STL_OFS_IRQ_STAT) begin
                irq_status <= events;
            end else begin
                irq_status <= irq_status | events;
            end
            if (wr_en) begin
                case (avs_address_in)
                    `STL_OFS_FWD_INT: forward_internal_torque_limit <=
                        clip_set(merge16(forward_internal_torque_limit,
                                         avs_writedata_in, avs_byteenable_in));
                    `STL_OFS_REV_INT: reverse_internal_torque_limit <=
                        clip_set(merge16(reverse_internal_torque_limit,
                                         avs_writedata_in, avs_byteenable_in));
                    `STL_OFS_ROUTING: output_signal_routing_two <=
                        merge16(output_signal_routing_two, avs_writedata_in, avs_byteenable_in);
                    `STL_OFS_FWD_EXT: forward_external_torque_limit <=
                        clip_set(merge16(forward_external_torque_limit,
                                         avs_writedata_in, avs_byteenable_in));
                    `STL_OFS_REV_EXT: reverse_external_torque_limit <=
                        clip_set(merge16(reverse_external_torque_limit,
                                         avs_writedata_in, avs_byteenable_in));
                    `STL_OFS_MAXTQ: motor_max_torque <=
                        merge16(motor_max_torque, avs_writedata_in, avs_byteenable_in);
                    `STL_OFS_IRQ_MASK: if (avs_byteenable_in[0]) begin
                        irq_mask <= avs_writedata_in[`STL_IRQ_W-1:0];
                    end
                    default: irq_mask <= irq_mask;
                endcase
            end
        end
    end
endmodule // stl_torque_limiter

// file: tb/stl_host_model.sv
// Purpose: Host side of the torque limiter
// Assumes: Levels change just after rising clk_in
// Notes: Bench calls set_io to move levels
module stl_host_model (
    input wire clk_in,
    output logic signed [15:0] ref_out = 16'sh0,
    output logic fwd_n_out = 1'b1,
    output logic rev_n_out = 1'b1,
    output logic [2:0] oth_out = 3'h0
);
    task automatic set_io(input logic [15:0] t, input logic f, r, input logic [2:0] o);
        @(posedge clk_in);
        ref_out <= t;
        fwd_n_out <= f;
        rev_n_out <= r;
        oth_out <= o;
    endtask
endmodule // stl_host_model

// file: tb/stl_torque_limiter_asserts.sv
// Purpose: Port checks of the torque limiter
// Assumes: One clock domain
// Notes: Bound to the design top
module stl_torque_limiter_chk (
    input wire clk_in,
    input wire reset_n_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire signed [15:0] torque_ref_in,
    input wire [2:0] other_out_func_in,
    input wire [15:0] active_limit_out,
    input wire torque_limited_n_out,
    input wire output_pair_first_n_out,
    input wire output_pair_second_n_out,
    input wire output_pair_third_n_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [15:0] mag = 16'h0;
    wire [2:0] pn = {output_pair_third_n_out, output_pair_second_n_out, output_pair_first_n_out};
    always @(posedge clk_in) mag <= torque_ref_in[15] ? -torque_ref_in : torque_ref_in;
    sequence req_s;
        (avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in);
    endsequence
    wait_first_a: assert property (req_s |-> avs_waitrequest_out)
        else $error("waitrequest low on first cycle");
    wait_end_a: assert property (req_s |=> !avs_waitrequest_out)
        else $error("waitrequest late");
    rdata_hold_a: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in))
        else $error("readdata moved without read");
    limited_cmp_a: assert property (torque_limited_n_out == !(mag > active_limit_out))
        else $error("limited status wrong");
    limit_cap_a: assert property (active_limit_out <= 16'h0320)
        else $error("limit above cap");
    pair_or_a: assert property (($past(other_out_func_in) & pn) == 3'h0)
        else $error("other function lost");
    pair_cause_a: assert property ((~pn & ~$past(other_out_func_in)) != 3'h0 |-> !torque_limited_n_out)
        else $error("pair low without cause");
    pair_one_a: assert property ($past(other_out_func_in) == 3'h0 |-> $countones(~pn) <= 1)
        else $error("status on several pairs");
endmodule // stl_torque_limiter_chk
bind stl_torque_limiter stl_torque_limiter_chk chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .torque_ref_in(torque_ref_in),
    .other_out_func_in(other_out_func_in), .active_limit_out(active_limit_out),
    .torque_limited_n_out(torque_limited_n_out), .output_pair_first_n_out(output_pair_first_n_out),
    .output_pair_second_n_out(output_pair_second_n_out),
    .output_pair_third_n_out(output_pair_third_n_out));

// file: tb/servo_torque_limiter_tb_top.sv
// Purpose: Register and status tests of the torque limiter
// Assumes: Host model drives contacts and torque reference
// Notes: Status compared three edges after a change
`include "stl_regs.vh"
module servo_torque_limiter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic rd = 1'b0, wr = 1'b0, wt, fn, rn, ltd, p1, p2, p3, irq;
    logic [5:0] adr = 6'h0;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [15:0] tq, lim;
    logic [2:0] oth;
    int fails = 0, num_checks = 0, cyc = 0;
    logic [5:0] ofs [6] = '{6'h00, 6'h04, 6'h0c, 6'h10, 6'h08, 6'h14};
    logic [31:0] rst [6] = '{32'h320, 32'h320, 32'h64, 32'h64, 32'h0, 32'h320};
    initial forever #12.5 clk_in = ~clk_in;
    stl_host_model host (.clk_in(clk_in), .ref_out(tq), .fwd_n_out(fn), .rev_n_out(rn),
        .oth_out(oth));
    stl_torque_limiter dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .torque_ref_in(tq),
        .forward_ext_limit_n_in(fn), .reverse_ext_limit_n_in(rn), .other_out_func_in(oth),
        .active_limit_out(lim), .torque_limited_n_out(ltd), .output_pair_first_n_out(p1),
        .output_pair_second_n_out(p2), .output_pair_third_n_out(p3), .irq_out(irq));
    task automatic test_done();
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_in);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_in); while (wt !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ofs[i], 32'h0);
            chk(q, rst[i]);
        end
        bus(1'b0, 6'h3c, 32'h0);
        chk(q, 32'h0);
        host.set_io(16'sd500, 1'b1, 1'b1, 3'h0);
        settle();
        chk({lim, 15'h0, ltd}, {16'h320, 16'h1});
        bus(1'b1, `STL_OFS_FWD_INT, 32'h12c);
        settle();
        chk({lim, 14'h0, irq, ltd}, {16'h12c, 16'h0});
        bus(1'b0, `STL_OFS_OUT_MON, 32'h0);
        chk(q[0], 1'b1);
        bus(1'b1, `STL_OFS_IRQ_MASK, 32'h1);
        settle();
        chk(irq, 1'b1);
        bus(1'b0, `STL_OFS_IRQ_STAT, 32'h0);
        settle();
        chk({q[0], irq}, 2'b10);
        bus(1'b1, `STL_OFS_MAXTQ, 32'hc8);
        settle();
        chk(lim, 16'hc8);
        bus(1'b1, `STL_OFS_MAXTQ, 32'h320);
        bus(1'b1, `STL_OFS_REV_INT, 32'h3e8);
        bus(1'b0, `STL_OFS_REV_INT, 32'h0);
        chk(q, 32'h320);
        host.set_io(16'sd500, 1'b0, 1'b1, 3'h0);
        settle();
        chk(lim, 16'h64);
        bus(1'b0, `STL_OFS_IN_MON, 32'h0);
        chk(q[7:6], 2'b01);
        host.set_io(-16'sd150, 1'b0, 1'b1, 3'h0);
        settle();
        chk({lim, 15'h0, ltd}, {16'h320, 16'h1});
        host.set_io(-16'sd150, 1'b0, 1'b0, 3'h0);
        settle();
        chk({lim, 15'h0, ltd}, {16'h64, 16'h0});
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, `STL_OFS_ROUTING, s);
            settle();
            chk({p3, p2, p1}, s == 0 ? 3'h7 : 3'(~(3'h1 << (s - 1))));
        end
        host.set_io(16'sd0, 1'b1, 1'b1, 3'h5);
        settle();
        chk({p3, p2, p1}, 3'h2);
        test_done();
    end
endmodule // servo_torque_limiter_tb_top
